// >>> rtl/gpio_pin_config_mux.v
// Pin configuration registers, function multiplexer and combined interrupts over APB
// How it works
// - bit 0 sets direction, one input, zero output
// - bit 1 inverts the pin value when one
// - group-one bit 2 adds pin to combined interrupt 1
// - groups five/six bit 5 adds pin to combined interrupt 2; bits 2,6 reserved
// - bit 7 selects open-drain when one, push-pull when zero
// - group-one bits 6:4 reserved; pin E3 bit 3 routes lamp output
// - pin E4 bit 3 connects second infrared receive input
// - pin E5 bit 3 drives second infrared transmit output
// - pin E6 bit 3 outputs floppy motor-on 1, active low
// - pin E7 bit 3 outputs floppy drive-select 1, active low
// - pin C8 field: PCI clock, interrupt 14, GPIO, reserved
// - pin CA field: density select, GPIO, interrupt 8, management interrupt
// - pin CB field: ROM chip select, interrupt 11, GPIO, edge interrupt 3
// - pin CC field: ROM output enable, interrupt 12, GPIO, edge interrupt 4
// - pin D0 field: ROM data 0, interrupt 1, GPIO, management interrupt
// - pin D1 field: ROM data 1, interrupt 3, GPIO, lamp output
// - pin D2 field: ROM data 2, interrupt 4, GPIO, ring indicate input
// - pin D3 field: ROM data 3, interrupt 5, GPIO, watchdog output
// - configuration registers reset to 0x01
// - register E5 resets to 0x00
// - register CA resets to 0x09
// - upper nibble of combined-interrupt register routes the group interrupt
// - bit 3 of combined-interrupt register enables debounce filter
//
// Pin vector order (bit n): 0=E3 1=E4 2=E5 3=E6 4=E7 5=C8 6=CA 7=CB 8=CC 9=D0 10=D1 11=D2 12=D3
//
// The implementer's own choice: register access over APB.
`include "gpio_pin_config_mux_map.vh"

module gpio_pin_config_mux #(
  parameter NPINS = `NPINS
) (
  input  wire              i_clk,
  input  wire              i_rst,
  input  wire              i_psel,
  input  wire              i_penable,
  input  wire              i_pwrite,
  input  wire [11:0]       i_paddr,
  input  wire [31:0]       i_pwdata,
  output wire              o_pready,
  output reg  [31:0]       o_prdata,
  output wire              o_pslverr,
  input  wire [NPINS-1:0]  i_pin,
  output reg  [NPINS-1:0]  o_pin,
  output reg  [NPINS-1:0]  o_pin_oe,
  // Alternate-function sources driven onto pins
  input  wire              i_lamp,
  input  wire              i_infrared_transmit_2,
  input  wire              i_floppy_motor_on_1_low,
  input  wire              i_floppy_drive_select_1_low,
  input  wire              i_pci_clock,
  input  wire              i_drive_density_select_1,
  input  wire              i_system_mgmt_interrupt_low,
  input  wire              i_boot_rom_chip_select_low,
  input  wire              i_boot_rom_output_enable_low,
  input  wire [3:0]        i_rom_data_out,
  input  wire [3:0]        i_rom_data_oe,
  input  wire              i_watchdog_timer_output,
  // Alternate-function sinks taken from pins
  output reg               o_infrared_receive_2,
  output reg  [3:0]        o_rom_data_in,
  output reg               o_ring_indicate_low,
  output reg  [15:0]       o_irq_line,
  output reg  [4:3]        o_edge_irq,
  // Combined group interrupts, routing and filter settings
  output reg               o_group_irq_1,
  output reg               o_group_irq_2,
  output wire [3:0]        o_group_route_1,
  output wire [3:0]        o_group_route_2,
  output wire              o_group_filter_1,
  output wire              o_group_filter_2,
  output wire              o_group_route_bad_1,
  output wire              o_group_route_bad_2
);

  reg  [7:0]       cfg [0:NPINS-1];
  reg  [7:0]       int1_cfg;
  reg  [7:0]       int2_cfg;
  reg  [NPINS-1:0] pin_m;
  reg  [NPINS-1:0] pin_s;
  wire [NPINS-1:0] pin_v;
  reg  [NPINS-1:0] gpio_out;
  reg  [NPINS-1:0] gpio_in;
  reg  [7:0]       rd_byte;
  reg  [7:0]       idx_sel;
  reg              hit;
  // One loop variable per process so no variable has two drivers
  integer          n_wr;
  integer          n_rd;
  integer          n_in;
  integer          n_mux;
  integer          n_irq;
  integer          sel;

  // Register index for each pin slot
  function [7:0] pin_index;
    input integer p;
    begin
      case (p)
        0:       pin_index = `IDX_G1_B3;
        1:       pin_index = `IDX_G1_B4;
        2:       pin_index = `IDX_G1_B5;
        3:       pin_index = `IDX_G1_B6;
        4:       pin_index = `IDX_G1_B7;
        5:       pin_index = `IDX_G5_B0;
        6:       pin_index = `IDX_G5_B2;
        7:       pin_index = `IDX_G5_B3;
        8:       pin_index = `IDX_G5_B4;
        9:       pin_index = `IDX_G6_B0;
        10:      pin_index = `IDX_G6_B1;
        11:      pin_index = `IDX_G6_B2;
        default: pin_index = `IDX_G6_B3;
      endcase
    end
  endfunction

  function is_group1;
    input integer p;
    begin
      is_group1 = (p < 5);
    end
  endfunction

  function [7:0] reset_value;
    input integer p;
    begin
      if (p == 2)
        reset_value = `RST_G1_B5;
      else if (p == 6)
        reset_value = `RST_G5_B2;
      else
        reset_value = `RST_CFG;
    end
  endfunction

  // Two-stage pin synchroniser; only pin_s is read
  always @(posedge i_clk) begin
    pin_m <= i_pin;
    pin_s <= pin_m;
  end

  // Polarity between pin and internal logic
  genvar g;
  generate
    for (g = 0; g < NPINS; g = g + 1) begin : g_pol
      assign pin_v[g] = pin_s[g] ^ cfg[g][`F_POL];
    end
  endgenerate

  // APB: zero wait states, unmapped reads give zero and writes are dropped
  assign o_pready  = 1'b1;
  assign o_pslverr = 1'b0;
  wire       wr_en  = i_psel & i_penable & i_pwrite;
  wire [7:0] wr_idx = i_paddr[9:2];

  always @(posedge i_clk) begin
    if (i_rst) begin
      for (n_wr = 0; n_wr < NPINS; n_wr = n_wr + 1)
        cfg[n_wr] <= reset_value(n_wr);
      int1_cfg <= `RST_INT;
      int2_cfg <= `RST_INT;
    end else if (wr_en) begin
      for (n_wr = 0; n_wr < NPINS; n_wr = n_wr + 1)
        if (wr_idx == pin_index(n_wr))
          cfg[n_wr] <= i_pwdata[7:0] & (is_group1(n_wr) ? `MASK_G1 : `MASK_G56);
      if (wr_idx == `IDX_INT1)
        int1_cfg <= i_pwdata[7:0] & `MASK_INT;
      if (wr_idx == `IDX_INT2)
        int2_cfg <= i_pwdata[7:0] & `MASK_INT;
    end
  end

  always @* begin
    rd_byte = 8'h00;
    hit     = 1'b0;
    idx_sel = 8'h00;
    for (n_rd = 0; n_rd < NPINS; n_rd = n_rd + 1) begin
      idx_sel = pin_index(n_rd);
      if (wr_idx == idx_sel) begin
        rd_byte = cfg[n_rd];
        hit     = 1'b1;
      end
    end
    if (wr_idx == `IDX_INT1)
      rd_byte = int1_cfg;
    if (wr_idx == `IDX_INT2)
      rd_byte = int2_cfg;
  end

  // Read data registered in setup so it stands through the access phase
  always @(posedge i_clk) begin
    if (i_rst)
      o_prdata <= 32'h0000_0000;
    else if (i_psel & ~i_penable)
      o_prdata <= {24'h00_0000, rd_byte};
  end

  // GPIO data: a group-one output value is the alternate source bit, inverted when bit 1 is one,
  // when a function is selected; plain GPIO pins give their sampled value only to the combined interrupts
  always @* begin
    for (n_in = 0; n_in < NPINS; n_in = n_in + 1)
      gpio_in[n_in] = pin_v[n_in];
  end

  // Function multiplexer: decide what drives each pin and with what enable
  always @* begin
    gpio_out             = {NPINS{1'b0}};
    o_pin                = {NPINS{1'b0}};
    o_pin_oe             = {NPINS{1'b0}};
    o_infrared_receive_2 = 1'b1;
    o_rom_data_in        = 4'h0;
    o_ring_indicate_low  = 1'b1;
    o_irq_line           = 16'h0000;
    o_edge_irq           = 2'b00;
    sel                  = 0;
    for (n_mux = 0; n_mux < NPINS; n_mux = n_mux + 1) begin
      sel = 0;
      if (is_group1(n_mux))
        sel = cfg[n_mux][`F_FSEL_LO] ? 1 : 0;
      else
        sel = 2 + cfg[n_mux][`F_FSEL_HI:`F_FSEL_LO];
      gpio_out[n_mux] = 1'b0;
      // GPIO mode: pin is driven low when output, so only open-drain pulls exist
      if ((is_group1(n_mux) && sel == 0) ||
          (!is_group1(n_mux) &&
           cfg[n_mux][`F_FSEL_HI:`F_FSEL_LO] == ((n_mux == 6) ? `FN_1 : `FN_2))) begin
        o_pin_oe[n_mux] = ~cfg[n_mux][`F_DIR];
      end
    end
    // Group-one alternate functions
    if (cfg[0][`F_FSEL_LO]) begin
      o_pin[0] = i_lamp ^ cfg[0][`F_POL];
      o_pin_oe[0] = 1'b1;
    end
    if (cfg[1][`F_FSEL_LO])
      o_infrared_receive_2 = pin_v[1];
    if (cfg[2][`F_FSEL_LO]) begin
      o_pin[2] = i_infrared_transmit_2 ^ cfg[2][`F_POL];
      o_pin_oe[2] = 1'b1;
    end
    if (cfg[3][`F_FSEL_LO]) begin
      o_pin[3] = i_floppy_motor_on_1_low ^ cfg[3][`F_POL];
      o_pin_oe[3] = 1'b1;
    end
    if (cfg[4][`F_FSEL_LO]) begin
      o_pin[4] = i_floppy_drive_select_1_low ^ cfg[4][`F_POL];
      o_pin_oe[4] = 1'b1;
    end
    // Group five and six; interrupt lines are inputs, the reserved code drives nothing
    case (cfg[5][`F_FSEL_HI:`F_FSEL_LO])
      `FN_0: begin o_pin[5] = i_pci_clock; o_pin_oe[5] = 1'b1; end
      `FN_1: o_irq_line[14] = pin_v[5];
      default: ;
    endcase
    case (cfg[6][`F_FSEL_HI:`F_FSEL_LO])
      `FN_0: begin o_pin[6] = i_drive_density_select_1; o_pin_oe[6] = 1'b1; end
      `FN_2: o_irq_line[8] = pin_v[6];
      `FN_3: begin o_pin[6] = i_system_mgmt_interrupt_low; o_pin_oe[6] = 1'b1; end
      default: ;
    endcase
    case (cfg[7][`F_FSEL_HI:`F_FSEL_LO])
      `FN_0: begin o_pin[7] = i_boot_rom_chip_select_low; o_pin_oe[7] = 1'b1; end
      `FN_1: o_irq_line[11] = pin_v[7];
      `FN_3: o_edge_irq[3] = pin_v[7];
      default: ;
    endcase
    case (cfg[8][`F_FSEL_HI:`F_FSEL_LO])
      `FN_0: begin o_pin[8] = i_boot_rom_output_enable_low; o_pin_oe[8] = 1'b1; end
      `FN_1: o_irq_line[12] = pin_v[8];
      `FN_3: o_edge_irq[4] = pin_v[8];
      default: ;
    endcase
    case (cfg[9][`F_FSEL_HI:`F_FSEL_LO])
      `FN_0: begin
        o_pin[9] = i_rom_data_out[0];
        o_pin_oe[9] = i_rom_data_oe[0];
        o_rom_data_in[0] = pin_s[9];
      end
      `FN_1: o_irq_line[1] = pin_v[9];
      `FN_3: begin o_pin[9] = i_system_mgmt_interrupt_low; o_pin_oe[9] = 1'b1; end
      default: ;
    endcase
    case (cfg[10][`F_FSEL_HI:`F_FSEL_LO])
      `FN_0: begin
        o_pin[10] = i_rom_data_out[1];
        o_pin_oe[10] = i_rom_data_oe[1];
        o_rom_data_in[1] = pin_s[10];
      end
      `FN_1: o_irq_line[3] = pin_v[10];
      `FN_3: begin o_pin[10] = i_lamp; o_pin_oe[10] = 1'b1; end
      default: ;
    endcase
    case (cfg[11][`F_FSEL_HI:`F_FSEL_LO])
      `FN_0: begin
        o_pin[11] = i_rom_data_out[2];
        o_pin_oe[11] = i_rom_data_oe[2];
        o_rom_data_in[2] = pin_s[11];
      end
      `FN_1: o_irq_line[4] = pin_v[11];
      `FN_3: o_ring_indicate_low = pin_v[11];
      default: ;
    endcase
    case (cfg[12][`F_FSEL_HI:`F_FSEL_LO])
      `FN_0: begin
        o_pin[12] = i_rom_data_out[3];
        o_pin_oe[12] = i_rom_data_oe[3];
        o_rom_data_in[3] = pin_s[12];
      end
      `FN_1: o_irq_line[5] = pin_v[12];
      `FN_3: begin o_pin[12] = i_watchdog_timer_output; o_pin_oe[12] = 1'b1; end
      default: ;
    endcase
    // Open drain: a driven one becomes release, so the board pull-up sets the level
    for (n_mux = 0; n_mux < NPINS; n_mux = n_mux + 1)
      if (cfg[n_mux][`F_ODRAIN] && o_pin[n_mux])
        o_pin_oe[n_mux] = 1'b0;
  end

  // Combined group interrupts, registered so the outputs are glitch free
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_group_irq_1 <= 1'b0;
      o_group_irq_2 <= 1'b0;
    end else begin
      o_group_irq_1 <= 1'b0;
      o_group_irq_2 <= 1'b0;
      for (n_irq = 0; n_irq < NPINS; n_irq = n_irq + 1) begin
        if (is_group1(n_irq) && cfg[n_irq][`F_G1_IEN] && gpio_in[n_irq])
          o_group_irq_1 <= 1'b1;
        if (!is_group1(n_irq) && cfg[n_irq][`F_G56_IEN] && gpio_in[n_irq])
          o_group_irq_2 <= 1'b1;
      end
    end
  end

  // Routing nibble and filter bit go to the interrupt router outside this block
  assign o_group_route_1     = int1_cfg[7:4];
  assign o_group_route_2     = int2_cfg[7:4];
  assign o_group_route_bad_1 = (int1_cfg[7:4] == 4'h2);
  assign o_group_route_bad_2 = (int2_cfg[7:4] == 4'h2);
  assign o_group_filter_1    = int1_cfg[`F_FILT];
  assign o_group_filter_2    = int2_cfg[`F_FILT];

endmodule // gpio_pin_config_mux

// >>> rtl/gpio_pin_config_mux_map.vh
// Register indices, field positions and reset values for the pin configuration block
`ifndef GPIO_PIN_CONFIG_MUX_MAP_VH
`define GPIO_PIN_CONFIG_MUX_MAP_VH
// Register indices; byte address is four times the index
`define IDX_G5_B0      8'hC8
`define IDX_G5_B2      8'hCA
`define IDX_G5_B3      8'hCB
`define IDX_G5_B4      8'hCC
`define IDX_G6_B0      8'hD0
`define IDX_G6_B1      8'hD1
`define IDX_G6_B2      8'hD2
`define IDX_G6_B3      8'hD3
`define IDX_G1_B3      8'hE3
`define IDX_G1_B4      8'hE4
`define IDX_G1_B5      8'hE5
`define IDX_G1_B6      8'hE6
`define IDX_G1_B7      8'hE7
`define IDX_INT2       8'hEF
`define IDX_INT1       8'hF0
// Field positions
`define F_DIR          0
`define F_POL          1
`define F_G1_IEN       2
`define F_FSEL_LO      3
`define F_FSEL_HI      4
`define F_G56_IEN      5
`define F_ODRAIN       7
`define F_FILT         3
// Writable bit masks
`define MASK_G1        8'h8F
`define MASK_G56       8'hBB
`define MASK_INT       8'hF8
// Reset values
`define RST_CFG        8'h01
`define RST_G1_B5      8'h00
`define RST_G5_B2      8'h09
`define RST_INT        8'h00
// Function codes
`define FN_0           2'h0
`define FN_1           2'h1
`define FN_2           2'h2
`define FN_3           2'h3
`define NPINS          13
`endif

// >>> tb/gpio_pin_config_mux_properties.sv
// Concurrent checks on the pin configuration block's ports
`include "gpio_pin_config_mux_map.vh"
module gpio_pin_config_mux_properties #(
  parameter NPINS = 13
) (
  input wire logic             i_clk,
  input wire logic             i_rst,
  input wire logic             i_psel,
  input wire logic             i_penable,
  input wire logic             i_pwrite,
  input wire logic [11:0]      i_paddr,
  input wire logic [31:0]      i_pwdata,
  input wire logic [31:0]      o_prdata,
  input wire logic [NPINS-1:0] o_pin,
  input wire logic [NPINS-1:0] o_pin_oe,
  input wire logic             i_infrared_transmit_2,
  input wire logic             i_floppy_motor_on_1_low,
  input wire logic [3:0]       o_group_route_1,
  input wire logic             o_group_filter_1,
  input wire logic             o_group_route_bad_1
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence wr(idx);
    i_psel && i_penable && i_pwrite && i_paddr[9:2] == idx;
  endsequence
  sequence rd_setup(idx);
    i_psel && !i_penable && !i_pwrite && i_paddr[9:2] == idx;
  endsequence
  a_dir_input_release: assert property (
    wr(`IDX_G1_B5) ##0 (i_pwdata[0] && !i_pwdata[3]) |=> !o_pin_oe[2])
    else $error("input pin still driven");
  a_tx_routed: assert property (
    wr(`IDX_G1_B5) ##0 i_pwdata[7:0] == 8'h08 |=> o_pin_oe[2] && o_pin[2] == i_infrared_transmit_2)
    else $error("transmit not on pin");
  a_open_drain_high: assert property (
    wr(`IDX_G1_B5) ##0 (i_pwdata[7:0] == 8'h88 && i_infrared_transmit_2) |=> !o_pin_oe[2])
    else $error("open drain drives high");
  a_motor_routed: assert property (
    wr(`IDX_G1_B6) ##0 i_pwdata[7:0] == 8'h08 |=> o_pin_oe[3] && o_pin[3] == i_floppy_motor_on_1_low)
    else $error("motor signal not on pin");
  a_route_written: assert property (
    wr(`IDX_INT1) |=> o_group_route_1 == $past(i_pwdata[7:4])) else $error("route not updated");
  a_filter_written: assert property (
    wr(`IDX_INT1) |=> o_group_filter_1 == $past(i_pwdata[3])) else $error("filter not updated");
  a_route_invalid: assert property (
    o_group_route_bad_1 == (o_group_route_1 == 4'h2)) else $error("invalid route flag wrong");
  a_reset_clears: assert property (disable iff (1'b0)
    i_rst |=> o_group_route_1 == 4'h0 && !o_group_filter_1) else $error("reset left route set");
  a_unmapped_zero: assert property (
    rd_setup(8'h00) |=> o_prdata == 32'h0) else $error("unmapped read not zero");
endmodule // gpio_pin_config_mux_properties

// >>> tb/pin_board_model.sv
// Board side of the pins: each pad shows the block's drive or the board's own level
module pin_board_model (
  input  wire logic [12:0] i_drive,
  input  wire logic [12:0] i_drive_en,
  input  wire logic [12:0] i_board,
  output wire logic [12:0] o_level
);
  // Released open-drain pads fall back to the board level, standing in for the pull-up
  assign o_level = (i_drive_en & i_drive) | (~i_drive_en & i_board);
endmodule // pin_board_model

// >>> tb/tb_gpio_pin_config_mux.sv
// Self-checking bench for the pin configuration block
module tb_gpio_pin_config_mux;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, ir_rx, ring_n, g1, g2, rbad1, rbad2, filt1, filt2;
  logic [12:0] pin_in, pin_out, pin_oe, board = '0;
  logic [17:0] src = '0;
  logic [15:0] irq;
  logic [3:0]  rom_in, route1, route2;
  logic [4:3]  edge_irq;
  int          bad_count = 0, n_compared = 0;
  // Row: write flag, index, write data, expected read-back
  localparam logic [27:0] rows [13] = '{28'h0E50000, 28'h0CA0009, 28'h0C80001, 28'h0D30001,
    28'h0E40001, 28'h0F00000, 28'h1E4FF8F, 28'h1C8FFBB, 28'h1F0FFF8, 28'h1E5FF8F,
    28'h1E60808, 28'h100FF00, 28'h1CA0000};
  gpio_pin_config_mux gpio_pin_config_mux_i (.i_clk(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_pin(pin_in),
    .o_pin(pin_out), .o_pin_oe(pin_oe), .i_lamp(src[0]), .i_infrared_transmit_2(src[1]),
    .i_floppy_motor_on_1_low(src[2]), .i_floppy_drive_select_1_low(src[3]),
    .i_pci_clock(src[4]), .i_drive_density_select_1(src[5]),
    .i_system_mgmt_interrupt_low(src[6]), .i_boot_rom_chip_select_low(src[7]),
    .i_boot_rom_output_enable_low(src[8]), .i_rom_data_out(src[12:9]),
    .i_rom_data_oe(src[16:13]), .i_watchdog_timer_output(src[17]),
    .o_infrared_receive_2(ir_rx), .o_rom_data_in(rom_in), .o_ring_indicate_low(ring_n),
    .o_irq_line(irq), .o_edge_irq(edge_irq), .o_group_irq_1(g1), .o_group_irq_2(g2),
    .o_group_route_1(route1), .o_group_route_2(route2), .o_group_filter_1(filt1),
    .o_group_filter_2(filt2), .o_group_route_bad_1(rbad1), .o_group_route_bad_2(rbad2));
  pin_board_model pin_board_model_i (.i_drive(pin_out), .i_drive_en(pin_oe), .i_board(board),
    .o_level(pin_in));
  initial begin
    forever #4 clk = ~clk;
  end
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write one pin register, then look at that pin's enable and value
  task drive_chk(input logic [7:0] idx, input logic [7:0] d, input int p, input logic [1:0] e);
    apb(1'b1, idx, d);
    #1;
    chk({pin_oe[p], pin_out[p]}, {30'h0, e});
  endtask
  // Two sync edges plus the registered group output, with margin
  task settle;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    tally_and_finish;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 13; k++) begin
      if (rows[k][24]) apb(1'b1, rows[k][23:16], rows[k][15:8]);
      apb(1'b0, rows[k][23:16], 8'h00);
      chk(rd, {24'h0, rows[k][7:0]});
    end
    @(posedge clk);
    src[1] <= 1'b1;
    apb(1'b1, 8'hE5, 8'h08);
    #1;
    chk({pin_oe[2], pin_out[2]}, 32'h3);
    @(posedge clk);
    src[1] <= 1'b0;
    @(posedge clk);
    #1;
    chk({pin_oe[2], pin_out[2]}, 32'h2);
    @(posedge clk);
    src[1] <= 1'b1;
    apb(1'b1, 8'hE5, 8'h88);
    #1;
    chk(pin_oe[2], 32'h0);
    @(posedge clk);
    board[1] <= 1'b1;
    apb(1'b1, 8'hE4, 8'h05);
    settle;
    chk(g1, 32'h1);
    apb(1'b1, 8'hE4, 8'h07);
    settle;
    chk(g1, 32'h0);
    apb(1'b1, 8'hE4, 8'h09);
    settle;
    chk(ir_rx, 32'h1);
    @(posedge clk);
    board[1] <= 1'b0;
    settle;
    chk(ir_rx, 32'h0);
    apb(1'b1, 8'hD0, 8'h09);
    @(posedge clk);
    board[9] <= 1'b1;
    settle;
    chk(irq[1], 32'h1);
    apb(1'b1, 8'hF0, 8'h20);
    #1;
    chk(rbad1, 32'h1);
    apb(1'b1, 8'hF0, 8'h38);
    #1;
    chk({rbad1, filt1, route1}, 32'h13);
    apb(1'b1, 8'hEF, 8'h28);
    #1;
    chk({rbad2, filt2, route2}, 32'h32);
    chk(pslverr, 32'h0);
    @(posedge clk);
    src <= 18'h15555;
    drive_chk(8'hE7, 8'h08, 4, 2'h2);
    drive_chk(8'hE3, 8'h08, 0, 2'h3);
    drive_chk(8'hC8, 8'h00, 5, 2'h3);
    drive_chk(8'hC8, 8'h18, 5, 2'h0);
    drive_chk(8'hCA, 8'h18, 6, 2'h3);
    drive_chk(8'hCB, 8'h00, 7, 2'h2);
    drive_chk(8'hCC, 8'h00, 8, 2'h3);
    drive_chk(8'hD0, 8'h18, 9, 2'h3);
    drive_chk(8'hD1, 8'h18, 10, 2'h3);
    drive_chk(8'hD1, 8'h00, 10, 2'h3);
    drive_chk(8'hD2, 8'h00, 11, 2'h0);
    drive_chk(8'hD3, 8'h18, 12, 2'h2);
    drive_chk(8'hD3, 8'h00, 12, 2'h3);
    drive_chk(8'hD0, 8'h00, 9, 2'h0);
    chk(rom_in[0], 32'h1);
    @(posedge clk);
    board[5] <= 1'b1;
    board[7] <= 1'b1;
    board[8] <= 1'b1;
    apb(1'b1, 8'hD2, 8'h19);
    apb(1'b1, 8'hCB, 8'h19);
    apb(1'b1, 8'hC8, 8'h09);
    apb(1'b1, 8'hCC, 8'h31);
    settle;
    chk(ring_n, 32'h0);
    chk(edge_irq[3], 32'h1);
    chk(irq[14], 32'h1);
    chk(g2, 32'h1);
    @(posedge clk);
    board[8] <= 1'b0;
    settle;
    chk(g2, 32'h0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'hF0, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, 8'hE5, 8'h00);
    chk(rd, 32'h0);
    tally_and_finish;
  end
endmodule // tb_gpio_pin_config_mux
bind gpio_pin_config_mux gpio_pin_config_mux_properties #(.NPINS(NPINS)) chk_i (.*);
